// ===== brake_seq_pkg.sv
// package for the holding brake sequencer: register map, field layout, timing
// assumes an apb slave with 32-bit data and a 100 MHz drive clock
package brake_seq_pkg;
   // register byte offsets
   localparam logic [11:0] OFS_OUTPUT_SELECT = 12'h000;
   localparam logic [11:0] OFS_RELEASE_DELAY = 12'h004;
   localparam logic [11:0] OFS_ENGAGE_DELAY  = 12'h008;
   localparam logic [11:0] OFS_SPEED_THRESH  = 12'h00C;
   localparam logic [11:0] OFS_TIMEOUT       = 12'h010;
   localparam logic [11:0] OFS_STATUS        = 12'h014;
   // output select: three 4-bit fields
   localparam int          SEL_FIELD_W       = 4;
   localparam logic [3:0]  BRAKE_FUNC_CODE   = 4'h4;
   // reset values
   localparam logic [11:0] SEL_RESET         = 12'h000;
   localparam logic [11:0] RELEASE_RESET     = 12'h000;
   localparam logic [8:0]  ENGAGE_RESET      = 9'h000;
   localparam logic [6:0]  THRESH_RESET      = 7'h64;
   localparam logic [6:0]  TIMEOUT_RESET     = 7'h32;
   // setting limits
   localparam int          RELEASE_MIN       = -2000;
   localparam int          RELEASE_MAX       = 2000;
   localparam int          ENGAGE_MAX        = 500;
   localparam int          THRESH_MIN        = 10;
   localparam int          THRESH_MAX        = 100;
   localparam int          TIMEOUT_MIN       = 10;
   localparam int          TIMEOUT_MAX       = 100;
   // time base
   localparam int          CLK_MHZ           = 100;
   localparam int          TICK_US           = 1000;
   localparam int          TICK_CYCLES       = CLK_MHZ * TICK_US;
   localparam int          UNIT_10MS         = 10;
   // status bit positions
   localparam int          ST_POWER          = 0;
   localparam int          ST_BRAKE          = 1;
   localparam int          ST_ACTIVE         = 2;
   localparam int          ST_STATE_LSB      = 4;

   typedef enum logic [2:0] {
      S_OFF      = 3'b000,
      S_REL_WAIT = 3'b001,
      S_ON       = 3'b010,
      S_ENG_WAIT = 3'b011,
      S_STOPPING = 3'b100
   } seq_state_e;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } apb_rsp_s;
endpackage : brake_seq_pkg

// ===== holding_brake_sequencer.sv
// holding brake sequencer: brake release output and motor power enable
// assumes synchronous inputs on CLK, speed magnitude in rpm, apb master
//
// Function
// RL1 - the brake output goes to each of three outputs whose select field holds the brake code.
// RL2 - brake timing only acts while some output is assigned the brake function.
// RL3 - a signed release delay in ms, -2000 to 2000, default 0, governs stationary enabling.
// RL4 - a positive release delay releases the brake first and powers the motor after it.
// RL5 - a negative release delay powers the motor first and releases the brake after its size.
// RL6 - stationary disable engages the brake then cuts power after the engage delay in 10 ms.
// RL7 - an alarm cuts motor power at once whatever the engage delay.
// RL8 - alarm or servo-off in motion cuts power, stops, and later drops the brake release.
// RL9 - in motion the brake engages once speed falls below the threshold, 10 to 100 rpm.
// RL10 - in motion the brake also engages when the timeout in 10 ms units expires first.
// RL11 - the host waits 50 ms plus brake release time after servo-on before any reference.
// RL12 - the motor counts as stationary when speed is below the threshold at disable.
`timescale 1ns/1ns
module holding_brake_sequencer #(
   parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES
) (
   input  wire logic                    CLK,
   input  wire logic                    RESET,
   input  wire brake_seq_pkg::apb_req_s APB_REQ,
   output      brake_seq_pkg::apb_rsp_s APB_RSP,
   input  wire logic                    SERVO_ON,
   input  wire logic                    ALARM,
   input  wire logic [15:0]             MOTOR_SPEED,
   output      logic                    MOTOR_POWER,
   output      logic [2:0]              DIGITAL_OUT
);
   typedef struct packed {
      logic [11:0]              sel;
      logic signed [11:0]       rel_delay;
      logic [8:0]               eng_delay;
      logic [6:0]               thresh;
      logic [6:0]               timeout;
      brake_seq_pkg::seq_state_e state;
      logic [31:0]              tick_cnt;
      logic [15:0]              ms_cnt;
      logic                     power;
      logic                     brake_rel;
      logic [2:0]               dout;
      logic [31:0]              prdata;
   } state_s;

   state_s st_reg;
   state_s st_next;

   // clamp a write value to a range
   function automatic logic [31:0] clamp(input logic [31:0] v, input int lo, input int hi);
      if ($signed(v) < lo) begin
         clamp = 32'(lo);
      end else if ($signed(v) > hi) begin
         clamp = 32'(hi);
      end else begin
         clamp = v;
      end
   endfunction : clamp

   // 10 ms units to milliseconds
   function automatic logic [15:0] tens_ms(input logic [8:0] v);
      tens_ms = 16'(v * brake_seq_pkg::UNIT_10MS);
   endfunction : tens_ms

   logic        brake_en;
   logic        stationary;
   logic        ms_tick;
   logic        access;
   logic [11:0] rel_mag;

   assign access  = APB_REQ.psel && APB_REQ.penable;
   assign ms_tick = (st_reg.tick_cnt == 32'(TICK_CYCLES - 1));
   assign rel_mag = st_reg.rel_delay[11] ? 12'(-st_reg.rel_delay) : st_reg.rel_delay;
   assign stationary = (MOTOR_SPEED < {9'h000, st_reg.thresh}); // see RL12

   always_comb begin
      brake_en = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (st_reg.sel[i*brake_seq_pkg::SEL_FIELD_W +: brake_seq_pkg::SEL_FIELD_W]
             == brake_seq_pkg::BRAKE_FUNC_CODE) begin
            brake_en = 1'b1; // see RL2
         end
      end
   end

   always_comb begin
      st_next = st_reg;
      // millisecond time base, restarted on leaving S_OFF and S_ON
      st_next.tick_cnt = ms_tick ? 32'h00000000 : st_reg.tick_cnt + 32'h00000001;
      if (ms_tick) begin
         st_next.ms_cnt = st_reg.ms_cnt + 16'h0001;
      end

      case (st_reg.state)
         brake_seq_pkg::S_OFF: begin
            st_next.power     = 1'b0;
            st_next.brake_rel = 1'b0;
            if (SERVO_ON && !ALARM) begin
               st_next.ms_cnt   = 16'h0000;
               st_next.tick_cnt = 32'h00000000;
               if (!brake_en || st_reg.rel_delay == 12'sh000) begin
                  st_next.power     = 1'b1;
                  st_next.brake_rel = brake_en;
                  st_next.state     = brake_seq_pkg::S_ON;
               end else if (!st_reg.rel_delay[11]) begin
                  st_next.brake_rel = 1'b1; // see RL4
                  st_next.state     = brake_seq_pkg::S_REL_WAIT;
               end else begin
                  st_next.power = 1'b1; // see RL5
                  st_next.state = brake_seq_pkg::S_REL_WAIT;
               end
            end
         end
         brake_seq_pkg::S_REL_WAIT: begin
            if (ALARM || !SERVO_ON) begin
               st_next.power     = 1'b0;
               st_next.brake_rel = 1'b0;
               st_next.state     = brake_seq_pkg::S_OFF;
            end else if (st_reg.ms_cnt >= {4'h0, rel_mag}) begin // see RL3
               st_next.power     = 1'b1; // see RL4
               st_next.brake_rel = 1'b1; // see RL5
               st_next.state     = brake_seq_pkg::S_ON;
            end
         end
         brake_seq_pkg::S_ON: begin
            st_next.brake_rel = brake_en;
            if (ALARM || !SERVO_ON) begin
               st_next.ms_cnt   = 16'h0000;
               st_next.tick_cnt = 32'h00000000;
               if (!brake_en) begin
                  st_next.power = 1'b0;
                  st_next.state = brake_seq_pkg::S_OFF;
               end else if (!stationary) begin
                  st_next.power = 1'b0; // see RL8
                  st_next.state = brake_seq_pkg::S_STOPPING;
               end else if (ALARM) begin
                  st_next.power     = 1'b0; // see RL7
                  st_next.brake_rel = 1'b0;
                  st_next.state     = brake_seq_pkg::S_OFF;
               end else begin
                  st_next.brake_rel = 1'b0; // see RL6
                  st_next.state     = brake_seq_pkg::S_ENG_WAIT;
               end
            end
         end
         brake_seq_pkg::S_ENG_WAIT: begin
            st_next.brake_rel = 1'b0;
            if (ALARM) begin
               st_next.power = 1'b0; // see RL7
               st_next.state = brake_seq_pkg::S_OFF;
            end else if (st_reg.ms_cnt >= tens_ms(st_reg.eng_delay)) begin
               st_next.power = 1'b0; // see RL6
               st_next.state = brake_seq_pkg::S_OFF;
            end
         end
         brake_seq_pkg::S_STOPPING: begin
            st_next.power = 1'b0;
            if (stationary) begin
               st_next.brake_rel = 1'b0; // see RL9
               st_next.state     = brake_seq_pkg::S_OFF;
            end else if (st_reg.ms_cnt >= tens_ms({2'b00, st_reg.timeout})) begin
               st_next.brake_rel = 1'b0; // see RL10
               st_next.state     = brake_seq_pkg::S_OFF;
            end
         end
         default: begin
            st_next.power     = 1'b0;
            st_next.brake_rel = 1'b0;
            st_next.state     = brake_seq_pkg::S_OFF;
         end
      endcase

      // brake output routing
      for (int i = 0; i < 3; i++) begin
         st_next.dout[i] = st_next.brake_rel &&
            (st_next.sel[i*brake_seq_pkg::SEL_FIELD_W +: brake_seq_pkg::SEL_FIELD_W]
             == brake_seq_pkg::BRAKE_FUNC_CODE); // see RL1
      end

      // apb register access, single-cycle answer
      if (access && APB_REQ.pwrite) begin
         case (APB_REQ.paddr)
            brake_seq_pkg::OFS_OUTPUT_SELECT: st_next.sel = APB_REQ.pwdata[11:0];
            brake_seq_pkg::OFS_RELEASE_DELAY: st_next.rel_delay = 12'(clamp(APB_REQ.pwdata,
               brake_seq_pkg::RELEASE_MIN, brake_seq_pkg::RELEASE_MAX)); // see RL3
            brake_seq_pkg::OFS_ENGAGE_DELAY: st_next.eng_delay = 9'(clamp(APB_REQ.pwdata,
               0, brake_seq_pkg::ENGAGE_MAX)); // see RL6
            brake_seq_pkg::OFS_SPEED_THRESH: st_next.thresh = 7'(clamp(APB_REQ.pwdata,
               brake_seq_pkg::THRESH_MIN, brake_seq_pkg::THRESH_MAX)); // see RL9
            brake_seq_pkg::OFS_TIMEOUT: st_next.timeout = 7'(clamp(APB_REQ.pwdata,
               brake_seq_pkg::TIMEOUT_MIN, brake_seq_pkg::TIMEOUT_MAX)); // see RL10
            default: begin
            end
         endcase
      end
      st_next.prdata = 32'h00000000;
      if (APB_REQ.psel && !APB_REQ.penable && !APB_REQ.pwrite) begin
         case (APB_REQ.paddr)
            brake_seq_pkg::OFS_OUTPUT_SELECT: st_next.prdata = {20'h00000, st_reg.sel};
            brake_seq_pkg::OFS_RELEASE_DELAY:
               st_next.prdata = {{20{st_reg.rel_delay[11]}}, st_reg.rel_delay};
            brake_seq_pkg::OFS_ENGAGE_DELAY: st_next.prdata = {23'h000000, st_reg.eng_delay};
            brake_seq_pkg::OFS_SPEED_THRESH: st_next.prdata = {25'h0000000, st_reg.thresh};
            brake_seq_pkg::OFS_TIMEOUT: st_next.prdata = {25'h0000000, st_reg.timeout};
            brake_seq_pkg::OFS_STATUS: begin
               st_next.prdata[brake_seq_pkg::ST_POWER]  = st_reg.power;
               st_next.prdata[brake_seq_pkg::ST_BRAKE]  = st_reg.brake_rel;
               st_next.prdata[brake_seq_pkg::ST_ACTIVE] = brake_en;
               st_next.prdata[brake_seq_pkg::ST_STATE_LSB +: 3] = st_reg.state;
            end
            default: st_next.prdata = 32'h00000000;
         endcase
      end else if (access) begin
         st_next.prdata = st_reg.prdata;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         st_reg.sel       <= brake_seq_pkg::SEL_RESET;
         st_reg.rel_delay <= brake_seq_pkg::RELEASE_RESET;
         st_reg.eng_delay <= brake_seq_pkg::ENGAGE_RESET;
         st_reg.thresh    <= brake_seq_pkg::THRESH_RESET;
         st_reg.timeout   <= brake_seq_pkg::TIMEOUT_RESET;
         st_reg.state     <= brake_seq_pkg::S_OFF;
         st_reg.tick_cnt  <= 32'h00000000;
         st_reg.ms_cnt    <= 16'h0000;
         st_reg.power     <= 1'b0;
         st_reg.brake_rel <= 1'b0;
         st_reg.dout      <= 3'h0;
         st_reg.prdata    <= 32'h00000000;
      end else begin
         st_reg <= st_next;
      end
   end

   logic unmapped;
   assign unmapped = (APB_REQ.paddr > brake_seq_pkg::OFS_STATUS) || (APB_REQ.paddr[1:0] != 2'b00);

   assign APB_RSP.prdata  = st_reg.prdata;
   assign APB_RSP.pready  = 1'b1;
   assign APB_RSP.pslverr = access && unmapped;
   assign MOTOR_POWER     = st_reg.power;
   assign DIGITAL_OUT     = st_reg.dout;
endmodule : holding_brake_sequencer

// ===== brake_seq_monitor.sv
// checker for the holding brake sequencer, ports only
// assumes binding into holding_brake_sequencer, register writes seen on apb
`timescale 1ns/1ns
module brake_seq_monitor #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic                    CLK,
   input wire logic                    RESET,
   input wire brake_seq_pkg::apb_req_s APB_REQ,
   input wire brake_seq_pkg::apb_rsp_s APB_RSP,
   input wire logic                    SERVO_ON,
   input wire logic                    ALARM,
   input wire logic [15:0]             MOTOR_SPEED,
   input wire logic                    MOTOR_POWER,
   input wire logic [2:0]              DIGITAL_OUT
);
   logic [11:0] sel_m, sel_q;
   logic [6:0]  thr_m, tmo_m;
   logic [11:0] rel_m;
   logic [15:0] held_cnt;
   logic [2:0]  asg;
   logic        wr;
   int          lim;
   assign wr  = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
   assign asg = {sel_m[11:8] == brake_seq_pkg::BRAKE_FUNC_CODE,
                 sel_m[7:4] == brake_seq_pkg::BRAKE_FUNC_CODE,
                 sel_m[3:0] == brake_seq_pkg::BRAKE_FUNC_CODE};
   assign lim = int'(tmo_m) * brake_seq_pkg::UNIT_10MS * TICK_CYCLES + TICK_CYCLES + 1;
   // mirror of the settings, and time spent braking-released with power off
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         sel_m    <= brake_seq_pkg::SEL_RESET;
         sel_q    <= brake_seq_pkg::SEL_RESET;
         thr_m    <= brake_seq_pkg::THRESH_RESET;
         tmo_m    <= brake_seq_pkg::TIMEOUT_RESET;
         rel_m    <= brake_seq_pkg::RELEASE_RESET;
         held_cnt <= 16'h0000;
      end else begin
         if (wr && APB_REQ.paddr == brake_seq_pkg::OFS_RELEASE_DELAY) begin
            rel_m <= APB_REQ.pwdata[11:0];
         end
         sel_q <= sel_m;
         if (wr && APB_REQ.paddr == brake_seq_pkg::OFS_OUTPUT_SELECT) sel_m <= APB_REQ.pwdata[11:0];
         if (wr && APB_REQ.paddr == brake_seq_pkg::OFS_SPEED_THRESH) thr_m <= APB_REQ.pwdata[6:0];
         if (wr && APB_REQ.paddr == brake_seq_pkg::OFS_TIMEOUT) tmo_m <= APB_REQ.pwdata[6:0];
         held_cnt <= (!SERVO_ON && !MOTOR_POWER && DIGITAL_OUT != 3'h0) ? held_cnt + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence servo_rise;
      !SERVO_ON ##1 SERVO_ON && !ALARM && !MOTOR_POWER && DIGITAL_OUT == 3'h0;
   endsequence
   sequence servo_fall;
      SERVO_ON ##1 !SERVO_ON && !ALARM && MOTOR_POWER;
   endsequence
   chk_route_field: assert property (sel_m == sel_q |-> DIGITAL_OUT == 3'h0 || DIGITAL_OUT == asg)
      else $error("brake output on a wrong channel");
   chk_plain_on: assert property (servo_rise ##0 asg == 3'h0 |=> MOTOR_POWER && DIGITAL_OUT == 3'h0)
      else $error("unassigned servo-on not immediate");
   chk_first_step: assert property (servo_rise ##0 (asg != 3'h0 && rel_m != 12'h000)
      |=> MOTOR_POWER != (DIGITAL_OUT != 3'h0))
      else $error("servo-on first step wrong");
   chk_stop_engage: assert property (servo_fall ##0 (DIGITAL_OUT != 3'h0 && MOTOR_SPEED < thr_m) |=> DIGITAL_OUT == 3'h0)
      else $error("stationary stop did not engage brake");
   chk_alarm_cut: assert property ($rose(ALARM) |=> !MOTOR_POWER)
      else $error("alarm did not cut power");
   chk_motion_cut: assert property (servo_fall ##0 (MOTOR_SPEED >= thr_m && DIGITAL_OUT != 3'h0) |=> !MOTOR_POWER && DIGITAL_OUT == $past(DIGITAL_OUT))
      else $error("moving stop sequence wrong");
   chk_speed_engage: assert property (!SERVO_ON && !MOTOR_POWER && DIGITAL_OUT != 3'h0 && MOTOR_SPEED < thr_m |=> DIGITAL_OUT == 3'h0)
      else $error("brake not engaged below threshold");
   chk_timeout_bound: assert property (int'(held_cnt) <= lim)
      else $error("brake held past timeout");
endmodule : brake_seq_monitor
bind holding_brake_sequencer brake_seq_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (.CLK(CLK), .RESET(RESET),
   .APB_REQ(APB_REQ), .APB_RSP(APB_RSP), .SERVO_ON(SERVO_ON), .ALARM(ALARM),
   .MOTOR_SPEED(MOTOR_SPEED), .MOTOR_POWER(MOTOR_POWER), .DIGITAL_OUT(DIGITAL_OUT));

// ===== host_model.sv
// host controller model: servo-on command and motion reference permission
// assumes the bench asks for servo-on; t_pos waits for ref_ok, t_neg applies motion speed without it
`timescale 1ns/1ns
module host_model #(
   parameter int TICK_CYCLES = 10
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        want_on,
   input  wire logic [15:0] release_ms,
   output      logic        servo_on,
   output      logic        ref_ok
);
   int wait_cnt;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         servo_on <= 1'b0;
         ref_ok   <= 1'b0;
         wait_cnt <= 0;
      end else begin
         servo_on <= want_on;
         wait_cnt <= servo_on ? wait_cnt + 1 : 0;
         ref_ok   <= servo_on && wait_cnt >= (50 + int'(release_ms)) * TICK_CYCLES;
      end
   end
endmodule : host_model

// ===== holding_brake_sequencer_tb.sv
// self-checking bench for the holding brake sequencer
// assumes TICK_CYCLES of 10, so one millisecond is ten clocks
`timescale 1ns/1ns
module holding_brake_sequencer_tb;
   localparam int T = 10;
   logic clk = 0, reset = 1, want_on = 0, alarm = 0, servo_on, ref_ok, power, e;
   logic [15:0] speed = 16'h0000, rel_ms = 16'h0000;
   logic [2:0] dout;
   logic [31:0] q;
   brake_seq_pkg::apb_req_s req = '0;
   brake_seq_pkg::apb_rsp_s rsp;
   int errors = 0, n_tests = 0, n;
   always #5 clk = ~clk;
   holding_brake_sequencer #(.TICK_CYCLES(T)) DUT (.CLK(clk), .RESET(reset), .APB_REQ(req),
      .APB_RSP(rsp), .SERVO_ON(servo_on), .ALARM(alarm), .MOTOR_SPEED(speed),
      .MOTOR_POWER(power), .DIGITAL_OUT(dout));
   host_model #(.TICK_CYCLES(T)) host (.clk(clk), .reset(reset), .want_on(want_on),
      .release_ms(rel_ms), .servo_on(servo_on), .ref_ok(ref_ok));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
   endtask : apb
   function automatic logic cond(input int k);
      case (k)
         0: return power;
         1: return !power;
         2: return dout != 3'h0;
         3: return dout == 3'h0;
         default: return ref_ok;
      endcase
   endfunction : cond
   task automatic wait_c(input int k);
      n = 0;
      while (cond(k) !== 1'b1 && n < 20000) begin
         @(posedge clk);
         #1;
         n++;
      end
      check({31'h0, n < 20000}, 32'h1);
   endtask : wait_c
   task automatic near(input int m);
      check({31'h0, n >= m - 2 && n <= m + T}, 32'h1);
   endtask : near
   task automatic servo(input logic v);
      @(posedge clk);
      want_on <= v;
      repeat (3) @(posedge clk);
      #1;
   endtask : servo
   task automatic t_defaults;
      logic [31:0] exp [5];
      exp = '{32'h0, 32'h0, 32'h0, 32'h64, 32'h32};
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         check(q, exp[i]);
      end
      apb(1'b0, 12'h020, 32'h0);
      check(q, 32'h0);
      check({31'h0, e}, 32'h1);
      $display("defaults done");
   endtask : t_defaults
   task automatic t_plain;
      servo(1'b1);
      check({power, dout}, 4'h8);
      servo(1'b0);
      check({power, dout}, 4'h0);
      $display("plain done");
   endtask : t_plain
   task automatic t_pos;
      apb(1'b1, 12'h000, 32'h004);
      apb(1'b1, 12'h004, 32'h5);
      apb(1'b1, 12'h008, 32'h2);
      rel_ms <= 16'h0005;
      servo(1'b1);
      check({power, dout}, 4'h1);
      wait_c(0);
      near(5 * T);
      wait_c(4);
      servo(1'b0);
      check({power, dout}, 4'h8);
      wait_c(1);
      near(20 * T);
      $display("positive done");
   endtask : t_pos
   task automatic t_neg;
      apb(1'b1, 12'h000, 32'h440);
      apb(1'b1, 12'h004, 32'hFFFFFFFD);
      apb(1'b1, 12'h00C, 32'h14);
      apb(1'b1, 12'h010, 32'hA);
      for (int k = 0; k < 2; k++) begin
         servo(1'b1);
         check({power, dout}, 4'h8);
         wait_c(2);
         near(3 * T);
         check(dout, 3'h6);
         @(posedge clk);
         speed <= 16'h01F4;
         servo(1'b0);
         check({power, dout}, 4'h6);
         if (k == 0) begin
            speed <= 16'h0005;
            wait_c(3);
            check({31'h0, n <= 2}, 32'h1);
         end else begin
            wait_c(3);
            near(100 * T);
         end
         @(posedge clk);
         speed <= 16'h0000;
      end
      $display("negative and motion done");
   endtask : t_neg
   task automatic t_alarm;
      apb(1'b1, 12'h008, 32'h32);
      servo(1'b1);
      wait_c(2);
      @(posedge clk);
      alarm <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check(power, 1'b0);
      servo(1'b0);
      alarm <= 1'b0;
      $display("alarm done");
   endtask : t_alarm
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   initial begin
      #500000;
      errors++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      t_defaults();
      t_plain();
      t_pos();
      t_neg();
      t_alarm();
      complete_run();
   end
endmodule : holding_brake_sequencer_tb
